//--- pkg/twl_pkg.sv
// package: constants and types of the three-wire latch loader
//
// Notes on behaviour
// (RULE_01) each rising serial clock edge shifts the data bit into a 24-bit register
// (RULE_02) words arrive msb first; the two lsbs select the target latch
// (RULE_03) load strobe rising copies the shift register into exactly one latch; the code copies on each serial clock rising edge with the strobe high
// (RULE_04) monitor pin shows lock detect, divided feedback or divided reference, as programmed
// (RULE_05) chip enable low powers down and floats the charge pump output
// (RULE_06) chip enable high powers up only as far as power-down bits allow
// (RULE_07) select 00 control, 01 r counter, 10 n counter, 11 test latch
// (RULE_08) host programs r counter, then control, then n counter latch after power-up
// (RULE_09) host never writes the factory test latch
// (RULE_10) host holds strobe low for all 24 bits, raising it after the last edge
package twl_pkg;
  localparam int WORD_W = 24;
  localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
  localparam int SEL_LSB = 0;
  // monitor select field in the control latch
  localparam int MON_LSB = 5;
  // software power-down bits in the control latch
  localparam int PD1_BIT = 20;
  localparam int PD2_BIT = 21;
  localparam logic [2:0] MON_LOCK = 3'h1;
  localparam logic [2:0] MON_NDIV = 3'h2;
  localparam logic [2:0] MON_RDIV = 3'h4;

  typedef enum logic [3:0] {
    TWL_SEL_CTRL = 4'h1,
    TWL_SEL_RCNT = 4'h2,
    TWL_SEL_NCNT = 4'h4,
    TWL_SEL_TEST = 4'h8
  } twl_sel_t;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [1:0]        sel;
    logic              tog;
  } twl_load_t;

  typedef struct packed {
    logic lock;
    logic ndiv;
    logic rdiv;
  } twl_mon_src_t;
endpackage : twl_pkg

//--- core/twl_shift.sv
// serial-clock-domain shift register and load capture
`timescale 1ns/1ps
`default_nettype none
module twl_shift (
  input  wire logic            ser_clk_i,
  input  wire logic            ser_data_i,
  input  wire logic            load_strobe_i,
  output var twl_pkg::twl_load_t load_o
);
  import twl_pkg::*;
  // no reset: the serial clock only runs while the host sends, so start values instead
  logic [WORD_W-1:0] sr_q = WORD_RST;
  logic [WORD_W-1:0] sr_d;
  twl_load_t         ld_q = '0;
  twl_load_t         ld_d;

  always_comb begin
    sr_d = {sr_q[WORD_W-2:0], ser_data_i}; // RULE_01 RULE_02
    ld_d = ld_q;
    // strobe sampled on the serial clock; the host keeps it low while shifting
    if (load_strobe_i) begin // RULE_10
      ld_d.word = sr_q;
      ld_d.sel  = sr_q[SEL_LSB+1:SEL_LSB];
      ld_d.tog  = ~ld_q.tog;
    end
  end

  always_ff @(posedge ser_clk_i) begin
    sr_q <= sr_d;
    ld_q <= ld_d;
  end

  assign load_o = ld_q;
endmodule : twl_shift
`default_nettype wire

//--- core/twl_loader.sv
// three-wire latch loader: latches, power control and monitor mux
`timescale 1ns/1ps
`default_nettype none
module twl_loader (
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  ser_clk_i,
  input  wire logic                  ser_data_i,
  input  wire logic                  latch_load_strobe_i,
  input  wire logic                  chip_enable_i,
  input  wire twl_pkg::twl_mon_src_t mon_src_i,
  output logic [twl_pkg::WORD_W-1:0] ctrl_latch_o,
  output logic [twl_pkg::WORD_W-1:0] rcnt_latch_o,
  output logic [twl_pkg::WORD_W-1:0] ncnt_latch_o,
  output logic [twl_pkg::WORD_W-1:0] test_latch_o,
  output logic                       powered_o,
  output logic                       charge_pump_out_oe_o,
  output logic                       monitor_output_pin_o
);
  import twl_pkg::*;

  // one latch per select code
  localparam int NUM_LATCH = 4;

  // word, select and toggle from the serial domain
  twl_load_t              ld_s;

  // toggle synchroniser; word and select settle long before the toggle lands
  logic                   tog_s1_q;
  logic                   tog_s1_d;
  logic                   tog_s2_q;
  logic                   tog_s2_d;
  logic                   tog_seen_q;
  logic                   tog_seen_d;
  logic                   load_pulse;

  // chip enable synchroniser
  logic                   ce_s1_q;
  logic                   ce_s1_d;
  logic                   ce_s2_q;
  logic                   ce_s2_d;

  // monitor source synchroniser
  twl_mon_src_t           mon_s1_q;
  twl_mon_src_t           mon_s1_d;
  twl_mon_src_t           mon_s2_q;
  twl_mon_src_t           mon_s2_d;

  // latch selection
  twl_sel_t               sel;
  logic [NUM_LATCH-1:0]   wr_en;
  wire logic [NUM_LATCH-1:0][WORD_W-1:0] latch_all;

  // control latch fields
  logic [WORD_W-1:0]      ctrl_word;
  logic                   pd_any;
  logic [2:0]             mon_code;

  // power and pump control
  logic                   pwr_q;
  logic                   pwr_d;
  logic                   cp_oe_q;
  logic                   cp_oe_d;

  // monitor output
  logic                   mon_q;
  logic                   mon_d;

  twl_shift u_shift (
    .ser_clk_i     (ser_clk_i),
    .ser_data_i    (ser_data_i),
    .load_strobe_i (latch_load_strobe_i),
    .load_o        (ld_s)
  );

  // toggle crossing: two sync stages, then one stage to spot the edge
  always_comb begin
    tog_s1_d   = ld_s.tog;
    tog_s2_d   = tog_s1_q;
    tog_seen_d = tog_s2_q;
    load_pulse = tog_s2_q ^ tog_seen_q; // RULE_03
  end

  // no reset: the chain keeps tracking, so a word loaded before reset is not replayed
  always_ff @(posedge sys_clk_i) begin
    tog_s1_q   <= tog_s1_d;
    tog_s2_q   <= tog_s2_d;
    tog_seen_q <= tog_seen_d;
  end

  always_comb begin
    ce_s1_d = chip_enable_i;
    ce_s2_d = ce_s1_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ce_s1_q <= 1'b0;
      ce_s2_q <= 1'b0;
    end else begin
      ce_s1_q <= ce_s1_d;
      ce_s2_q <= ce_s2_d;
    end
  end

  always_comb begin
    mon_s1_d = mon_src_i;
    mon_s2_d = mon_s1_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mon_s1_q <= '0;
      mon_s2_q <= '0;
    end else begin
      mon_s1_q <= mon_s1_d;
      mon_s2_q <= mon_s2_d;
    end
  end

  // select decode; code 11 still lands in the test latch if a host sends it
  always_comb begin
    case (ld_s.sel) // RULE_07
      2'b00: begin
        sel = TWL_SEL_CTRL;
      end
      2'b01: begin
        sel = TWL_SEL_RCNT;
      end
      2'b10: begin
        sel = TWL_SEL_NCNT;
      end
      default: begin
        sel = TWL_SEL_TEST;
      end
    endcase
    wr_en = load_pulse ? sel : {NUM_LATCH{1'b0}}; // RULE_03
  end

  // the one-hot select lets only one latch take the word
  generate
    for (genvar gi = 0; gi < NUM_LATCH; gi++) begin : g_latch
      logic [WORD_W-1:0] lat_q;
      logic [WORD_W-1:0] lat_d;

      always_comb begin
        lat_d = lat_q;
        if (wr_en[gi]) begin
          lat_d = ld_s.word; // RULE_03
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          lat_q <= WORD_RST;
        end else begin
          lat_q <= lat_d;
        end
      end

      assign latch_all[gi] = lat_q;
    end
  endgenerate

  // fields read from the live control latch, so a new control word acts at once
  always_comb begin
    ctrl_word = latch_all[0];
    pd_any    = ctrl_word[PD1_BIT] | ctrl_word[PD2_BIT]; // RULE_06
    mon_code  = ctrl_word[MON_LSB+2:MON_LSB];
  end

  always_comb begin
    pwr_d   = ce_s2_q & ~pd_any; // RULE_05 RULE_06
    cp_oe_d = pwr_d; // RULE_05
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pwr_q   <= 1'b0;
      cp_oe_q <= 1'b0;
    end else begin
      pwr_q   <= pwr_d;
      cp_oe_q <= cp_oe_d;
    end
  end

  // unused codes park the pin low instead of leaving it at a stale source
  always_comb begin
    case (mon_code) // RULE_04
      MON_LOCK: begin
        mon_d = mon_s2_q.lock;
      end
      MON_NDIV: begin
        mon_d = mon_s2_q.ndiv;
      end
      MON_RDIV: begin
        mon_d = mon_s2_q.rdiv;
      end
      default: begin
        mon_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mon_q <= 1'b0;
    end else begin
      mon_q <= mon_d;
    end
  end

  assign ctrl_latch_o         = latch_all[0];
  assign rcnt_latch_o         = latch_all[1];
  assign ncnt_latch_o         = latch_all[2];
  assign test_latch_o         = latch_all[3];
  assign powered_o            = pwr_q;
  assign charge_pump_out_oe_o = cp_oe_q;
  assign monitor_output_pin_o = mon_q;
endmodule : twl_loader
`default_nettype wire

//--- bench/twl_props.sv
// assertions on the latch loader ports
`timescale 1ns/1ps
`default_nettype none
module twl_props (
  input wire logic                  sys_clk_i,
  input wire logic                  reset_i,
  input wire logic                  chip_enable_i,
  input wire twl_pkg::twl_mon_src_t mon_src_i,
  input wire logic [23:0]           ctrl_latch_o,
  input wire logic [23:0]           test_latch_o,
  input wire logic                  powered_o,
  input wire logic                  charge_pump_out_oe_o,
  input wire logic                  monitor_output_pin_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_pump_follows: assert property (charge_pump_out_oe_o == powered_o)
    else $error("pump enable mismatch");
  a_ce_low_off: assert property (!chip_enable_i [*4] |=> !powered_o)
    else $error("powered with ce low");
  a_pd_bits_off: assert property ((ctrl_latch_o[21:20] != 2'h0) [*5] |-> !powered_o)
    else $error("powered with pd bits");
  a_ce_high_on: assert property (
    (chip_enable_i && ctrl_latch_o[21:20] == 2'h0) [*4] |=> powered_o)
    else $error("not powered with ce high");
  a_mon_lock: assert property (
    (ctrl_latch_o[7:5] == 3'h1) [*2] |-> monitor_output_pin_o == $past(mon_src_i.lock, 3))
    else $error("monitor not showing lock");
  a_test_unused: assert property (test_latch_o == 24'h000000)
    else $error("test latch written");
  c_power: cover property ($rose(powered_o));
  c_ctrl: cover property ($changed(ctrl_latch_o));
  c_off: cover property ($fell(powered_o));
endmodule : twl_props
bind twl_loader twl_props i_twl_props (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .chip_enable_i(chip_enable_i),
  .mon_src_i(mon_src_i), .ctrl_latch_o(ctrl_latch_o), .test_latch_o(test_latch_o),
  .powered_o(powered_o), .charge_pump_out_oe_o(charge_pump_out_oe_o),
  .monitor_output_pin_o(monitor_output_pin_o)
);
`default_nettype wire

//--- bench/twl_host.sv
// host model driving the serial port
`timescale 1ns/1ps
`default_nettype none
module twl_host (
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic strobe_o
);
  initial {ser_clk_o, ser_data_o, strobe_o} = 3'h0;
  // clock idles between frames; data flips once released, no pull on it
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= -1; i--) begin
      ser_data_o = (i < 0) ? ~ser_data_o : w[i];
      strobe_o = (i < 0);
      #3 ser_clk_o = 1'b1;
      #3 ser_clk_o = 1'b0;
    end
    {strobe_o, ser_data_o} = {1'b0, ~ser_data_o};
  endtask : send
endmodule : twl_host
`default_nettype wire

//--- bench/tb.sv
// bench of the latch loader
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, chip_enable_i = 1'b0, monitor_output_pin_o;
  logic ser_clk_i, ser_data_i, latch_load_strobe_i, powered_o, charge_pump_out_oe_o;
  logic [23:0] ctrl_latch_o, rcnt_latch_o, ncnt_latch_o, test_latch_o;
  twl_pkg::twl_mon_src_t mon_src_i = 3'h4;
  wire [23:0] status = {21'h0, powered_o, charge_pump_out_oe_o, monitor_output_pin_o};
  int miscompares = 0, samples_checked = 0;
  initial forever #2 sys_clk_i = ~sys_clk_i;
  twl_host i_twl_host (.ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
    .strobe_o(latch_load_strobe_i));
  twl_loader i_twl_loader (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ser_clk_i(ser_clk_i),
    .ser_data_i(ser_data_i), .latch_load_strobe_i(latch_load_strobe_i),
    .chip_enable_i(chip_enable_i), .mon_src_i(mon_src_i), .ctrl_latch_o(ctrl_latch_o),
    .rcnt_latch_o(rcnt_latch_o), .ncnt_latch_o(ncnt_latch_o), .test_latch_o(test_latch_o),
    .powered_o(powered_o), .charge_pump_out_oe_o(charge_pump_out_oe_o),
    .monitor_output_pin_o(monitor_output_pin_o));
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    miscompares += int'(g !== e);
    if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
  endtask : chk
  // waits out the crossing into the system clock before judging
  task automatic load(input logic [23:0] w);
    i_twl_host.send(w);
    repeat (9) @(posedge sys_clk_i);
    #1 chk(w[1] ? ncnt_latch_o : w[0] ? rcnt_latch_o : ctrl_latch_o, w);
  endtask : load
  task automatic order_scn;
    load(24'h5a3c81);
    load(24'h8c0020);
    load(24'hc3a5f6);
    chk(rcnt_latch_o, 24'h5a3c81);
    chk(ctrl_latch_o, 24'h8c0020);
    chk(test_latch_o, 24'h000000);
  endtask : order_scn
  task automatic power_scn;
    chip_enable_i = 1'b1;
    load(24'h100020);
    chk(status, 24'h1);
    load(24'h000020);
    chk(status, 24'h7);
    mon_src_i = 3'h1;
    load(24'h000080);
    chk(status, 24'h7);
    load(24'h000040);
    chk(status, 24'h6);
    mon_src_i = 3'h2;
    chip_enable_i = 1'b0;
    load(24'h5a3c81);
    chk(status, 24'h1);
  endtask : power_scn
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    order_scn();
    power_scn();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
